// [include/psal_pkg.sv]
// Package of constants and carrier types for the program start alarm logic.
`default_nettype none
package psal_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ           = 20_000_000;
  localparam int DEB_TICK_NS      = 1000;
  localparam int DEB_TICK_CYC_RAW = (CLK_HZ / 1_000_000) * DEB_TICK_NS / 1000;
  localparam int DEB_TICK_CYC     = (DEB_TICK_CYC_RAW < 1) ? 1 : DEB_TICK_CYC_RAW;

  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_SCALE  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK   = 8'h0c;
  localparam logic [7:0] REG_STATE  = 8'h10;
  localparam logic [7:0] REG_HIST   = 8'h14;

  // Control register fields.
  localparam int CTRL_POL_NC_BIT   = 0;
  localparam int CTRL_SERVO_EN_BIT = 1;
  localparam int CTRL_FRST_BIT     = 2;
  localparam int CTRL_DEB_LSB      = 8;
  localparam int CTRL_HIDX_LSB     = 16;

  // Event bits of the status and mask registers.
  localparam int EV_HALT  = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_START = 2;
  localparam int EV_W     = 3;

  // Reset values.
  localparam logic       POL_NC_RST    = 1'b1;
  localparam logic [7:0] DEB_RST       = 8'h0a;
  localparam logic [7:0] SCALE_RST     = 8'h00;
  localparam logic [2:0] MASK_RST      = 3'h0;

  // Program fault subcodes.
  localparam logic [1:0] PF_BUSY  = 2'h0;
  localparam logic [1:0] PF_EMPTY = 2'h1;
  localparam logic [1:0] PF_EXEC  = 2'h2;
  localparam logic [1:0] PF_STOP  = 2'h3;

  localparam int HIST_N = 8;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } psal_bus_type;

  typedef struct packed {
    logic       valid;   // Channel holds at least one command.
    logic       pos_cmd; // Channel holds a positioning command.
    logic       blocked; // A command cannot run in the present state.
    logic [7:0] move_idx;
  } psal_chan_type;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_BUSY = 2'b01
  } psal_run_type;

endpackage
`default_nettype wire

// [rtl/psal_core.sv]
// Emergency halt and program start checking for a servo motor driver.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
// Functional notes
// - While halt input active: servo off, dynamic brake on, halt alarm shown.
// - Halt alarm clears by itself once the halt input is released.
// - Halt input polarity defaults to normally closed and is configurable.
// - Normally closed: an open, unconnected halt input counts as active halt.
// - Start while in operation is ignored and raises program fault code 0.
// - Each rising edge of the start input is one start attempt.
// - Start input has a settable debounce time; it sits on input port five.
// - Selected channel without a command: refuse, raise program fault code 1.
// - Command not runnable in present state: refuse, raise fault code 2.
// - Positioning command from start runs only with servo on.
// - Channel data out of range, e.g. move index over divisions: code 2.
// - Start with halt request, alarm or inhibiting warning: fault code 3.
// - Fault clear input or fault reset command clears the program fault.
// - Every program fault code is logged in a readable alarm history.
module psal_core
  import psal_pkg::*;
(
  input  wire logic          ref_clk,              // 20 MHz clock.
  input  wire logic          rst,                  // Sync reset, active high.
  input  wire logic          ce,                   // Clock enable.
  input  wire psal_bus_type  bus,                  // Register request.
  output var  logic [31:0]   rdata,                // Read data, next cycle.
  output var  logic          irq,                  // Level interrupt.
  input  wire logic          emergency_halt_input, // High = contact closed.
  input  wire logic          input_port_five,      // Raw start input.
  input  wire logic [7:0]    program_channel_select, // Channel number.
  input  wire psal_chan_type chan,                 // Selected channel info.
  input  wire logic          fault_clear_input,    // Clears program fault.
  input  wire logic          halt_request_input,   // Stop request.
  input  wire logic          other_alarm_input,    // Inhibiting alarm.
  input  wire logic          exec_done,            // Program finished.
  output var  logic          servo_on,             // Motor servo on.
  output var  logic          dyn_brake,            // Dynamic brake engaged.
  output var  logic          halt_alarm_code,      // Halt alarm present.
  output var  logic          program_fault_code,   // Program fault warning.
  output var  logic [1:0]    fault_subcode,        // Last fault cause.
  output var  logic          in_operation,         // Program running.
  output var  logic          run_start,            // Start pulse.
  output var  logic [7:0]    run_channel           // Channel being run.
);

  // ------------------------------------------------------------------
  // State record
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0]  rdata;
    logic         irq;
    logic         pol_nc;
    logic         servo_en;
    logic [7:0]   deb_set;
    logic [2:0]   hidx;
    logic [7:0]   divisions;
    logic [2:0]   status;
    logic [2:0]   mask;
    logic         servo_on;
    logic         brake;
    logic         halt;
    logic         fault;
    logic [1:0]   code;
    psal_run_type run;
    logic         run_start;
    logic [7:0]   run_chan;
    logic         start_filt;
    logic         start_prev;
    logic [7:0]   deb_cnt;
    logic [15:0]  tick_cnt;
    logic [23:0]  hist;       // Eight entries of {valid, code}.
  } psal_state_type;

  localparam psal_state_type RST_STATE = '{
    rdata: 32'h0000_0000, irq: 1'b0, pol_nc: POL_NC_RST,
    servo_en: 1'b0, deb_set: DEB_RST, hidx: 3'h0,
    divisions: SCALE_RST, status: 3'h0, mask: MASK_RST,
    servo_on: 1'b0, brake: 1'b1, halt: 1'b0, fault: 1'b0,
    code: 2'h0, run: RUN_IDLE, run_start: 1'b0, run_chan: 8'h00,
    start_filt: 1'b0, start_prev: 1'b0, deb_cnt: 8'h00,
    tick_cnt: 16'h0000, hist: 24'h00_0000
  };

  psal_state_type s_q;
  psal_state_type s_d;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // Start checks take the edge and the halt flag from registered state, so a start and a halt
  // arriving together resolve in one deterministic cycle.
  always_comb begin
    logic       halt_now;
    logic       tick;
    logic       edge_seen;
    logic       refuse;
    logic [1:0] why;
    logic [2:0] ev;
    logic       frst;
    logic       fclr;
    s_d       = s_q;
    halt_now  = 1'b0;
    tick      = 1'b0;
    edge_seen = 1'b0;
    refuse    = 1'b0;
    why       = PF_BUSY;
    ev        = 3'h0;
    frst      = 1'b0;
    fclr      = 1'b0;

    // Normally closed reads an open wire as halt, the safe failure.
    halt_now = s_q.pol_nc ? ~emergency_halt_input
                          : emergency_halt_input;

    // Halt alarm follows the input level and so clears on release.
    s_d.halt     = halt_now;
    s_d.servo_on = s_q.servo_en & ~halt_now;
    s_d.brake    = ~s_q.servo_en | halt_now;
    if (halt_now && !s_q.halt) begin
      ev[EV_HALT] = 1'b1;
    end

    // Debounce: the raw start must differ for deb_set ticks to be taken.
    // A mechanical contact still may chatter past a short setting.
    tick = (s_q.tick_cnt == 16'(DEB_TICK_CYC - 1));
    s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;
    if (input_port_five == s_q.start_filt) begin
      s_d.deb_cnt = 8'h00;
    end else if (s_q.deb_cnt >= s_q.deb_set) begin
      s_d.start_filt = input_port_five;
      s_d.deb_cnt    = 8'h00;
    end else if (tick) begin
      s_d.deb_cnt = s_q.deb_cnt + 8'h01;
    end
    s_d.start_prev = s_q.start_filt;
    edge_seen = s_q.start_filt & ~s_q.start_prev;

    // Program run sequencing.
    s_d.run_start = 1'b0;
    case (s_q.run)
      RUN_IDLE: begin
      end
      RUN_BUSY: begin
        if (exec_done || halt_now) begin
          s_d.run = RUN_IDLE;
        end
      end
      default: begin
        s_d.run = RUN_IDLE;
      end
    endcase

    // Start checks in priority order; the first cause found is reported.
    // The select lines are assumed settled before the edge.
    if (edge_seen) begin
      if (s_q.run != RUN_IDLE) begin
        refuse = 1'b1;
        why    = PF_BUSY;
      end else if (halt_request_input || s_q.halt ||
                   other_alarm_input) begin
        refuse = 1'b1;
        why    = PF_STOP;
      end else if (!chan.valid) begin
        refuse = 1'b1;
        why    = PF_EMPTY;
      end else if (chan.blocked ||
                   (chan.pos_cmd && !s_q.servo_on)) begin
        refuse = 1'b1;
        why    = PF_EXEC;
      end else if (chan.pos_cmd && chan.move_idx > s_q.divisions) begin
        refuse = 1'b1;
        why    = PF_EXEC;
      end
      if (!refuse) begin
        s_d.run         = RUN_BUSY;
        s_d.run_start   = 1'b1;
        s_d.run_chan    = program_channel_select;
        ev[EV_START]    = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (bus.wr) begin
      case (bus.addr)
        REG_CTRL: begin
          s_d.pol_nc   = bus.wdata[CTRL_POL_NC_BIT];
          s_d.servo_en = bus.wdata[CTRL_SERVO_EN_BIT];
          frst         = bus.wdata[CTRL_FRST_BIT];
          s_d.deb_set  = bus.wdata[CTRL_DEB_LSB +: 8];
          s_d.hidx     = bus.wdata[CTRL_HIDX_LSB +: 3];
        end
        REG_SCALE: s_d.divisions = bus.wdata[7:0];
        REG_MASK:  s_d.mask      = bus.wdata[EV_W-1:0];
        default: begin
        end
      endcase
    end

    // Program fault: clear first, so a refusal in the same cycle wins.
    fclr = fault_clear_input | frst;
    if (fclr) begin
      s_d.fault = 1'b0;
    end
    if (refuse) begin
      // A refused start never touches the run state.
      s_d.fault    = 1'b1;
      s_d.code     = why;
      ev[EV_FAULT] = 1'b1;
      s_d.hist     = {s_q.hist[20:0], 1'b1, why};
    end

    // Sticky status: a read clears it, but a new event the same cycle
    // stays set.
    if (bus.rd && bus.addr == REG_STATUS) begin
      s_d.status = ev;
    end else begin
      s_d.status = s_q.status | ev;
    end
    s_d.irq = |(s_d.status & s_q.mask);

    // ----------------------------------------------------------------
    // Register reads, answered in the next cycle
    // ----------------------------------------------------------------
    s_d.rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: begin
          s_d.rdata[CTRL_POL_NC_BIT]      = s_q.pol_nc;
          s_d.rdata[CTRL_SERVO_EN_BIT]    = s_q.servo_en;
          s_d.rdata[CTRL_DEB_LSB +: 8]    = s_q.deb_set;
          s_d.rdata[CTRL_HIDX_LSB +: 3]   = s_q.hidx;
        end
        REG_SCALE:  s_d.rdata[7:0]        = s_q.divisions;
        REG_STATUS: s_d.rdata[EV_W-1:0]   = s_q.status;
        REG_MASK:   s_d.rdata[EV_W-1:0]   = s_q.mask;
        REG_STATE: begin
          s_d.rdata[0]   = s_q.halt;
          s_d.rdata[1]   = s_q.fault;
          s_d.rdata[3:2] = s_q.code;
          s_d.rdata[4]   = (s_q.run == RUN_BUSY);
          s_d.rdata[5]   = s_q.servo_on;
          s_d.rdata[6]   = s_q.brake;
        end
        // Entry 0 is the newest fault; the alarm history query.
        REG_HIST:   s_d.rdata[2:0] = s_q.hist[3*s_q.hidx +: 3];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= RST_STATE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, each straight from the state record
  // ------------------------------------------------------------------
  assign rdata              = s_q.rdata;
  assign irq                = s_q.irq;
  assign servo_on           = s_q.servo_on;
  assign dyn_brake          = s_q.brake;
  assign halt_alarm_code    = s_q.halt;
  assign program_fault_code = s_q.fault;
  assign fault_subcode      = s_q.code;
  assign in_operation       = (s_q.run == RUN_BUSY);
  assign run_start          = s_q.run_start;
  assign run_channel        = s_q.run_chan;

endmodule
`default_nettype wire

// [rtl/psal_unused_placeholder_none.sv]
// Intentionally empty design file slot: holds no logic.
`default_nettype none
`default_nettype wire

// [verif/psal_core_asserts.sv]
// Concurrent checks on the ports of the program start alarm logic.
`default_nettype none
module psal_core_asserts
  import psal_pkg::*;
(
  input wire logic          ref_clk,              // Clock.
  input wire logic          rst,                  // Sync reset.
  input wire psal_bus_type  bus,                  // Register request.
  input wire logic [31:0]   rdata,                // Read data.
  input wire logic          emergency_halt_input, // Halt contact.
  input wire logic          halt_request_input,   // Stop request.
  input wire logic          other_alarm_input,    // Inhibiting alarm.
  input wire logic          fault_clear_input,    // Fault clear.
  input wire psal_chan_type chan,                 // Channel info.
  input wire logic          servo_on,             // Servo state.
  input wire logic          dyn_brake,            // Brake state.
  input wire logic          halt_alarm_code,      // Halt alarm.
  input wire logic          program_fault_code,   // Fault warning.
  input wire logic          in_operation,         // Running.
  input wire logic          run_start             // Start pulse.
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  // All checks share the one clock and its reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_HALT_SAFE: assert property (halt_alarm_code |-> !servo_on && dyn_brake)
    else $error("halt alarm without servo off and brake");
  AST_HALT_ENDS_RUN: assert property (halt_alarm_code[*2] |-> !in_operation)
    else $error("run survives a halt");
  // The alarm only moves after a pin change or a polarity write.
  AST_HALT_CAUSE: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
    && $changed(halt_alarm_code) |-> $past(emergency_halt_input) !=
    $past(emergency_halt_input, 2) || $past(bus.wr) || $past(bus.wr, 2)
    || $past(bus.wr, 3))
    else $error("halt alarm moved without cause");
  AST_START_PULSE: assert property (run_start |-> in_operation ##1 !run_start)
    else $error("start pulse not one cycle");
  AST_NO_START_BUSY: assert property (run_start |-> !$past(in_operation))
    else $error("start accepted while busy");
  AST_NO_START_EMPTY: assert property (run_start |-> $past(chan.valid))
    else $error("empty channel started");
  AST_NO_START_STOP: assert property (run_start |-> !$past(halt_request_input)
    && !$past(other_alarm_input))
    else $error("start accepted under stop or alarm");
  AST_FAULT_NO_RUN: assert property ($rose(program_fault_code) |-> !run_start
    && !$rose(in_operation))
    else $error("refused start still ran");
  // A refusal in the same cycle as the clear still sets the fault.
  AST_CLEAR_INPUT: assert property (fault_clear_input[*3] |->
    !program_fault_code || $rose(program_fault_code))
    else $error("fault not cleared by clear input");
  AST_CLEAR_CMD: assert property (bus.wr && bus.addr == REG_CTRL
    && bus.wdata[CTRL_FRST_BIT] |-> ##2 !program_fault_code)
    else $error("fault not cleared by reset command");
  AST_RDATA_IDLE: assert property (!$past(bus.rd) |-> rdata == 32'h0)
    else $error("read data outside its cycle");

  C_RUN: cover property (run_start);
  C_FAULT: cover property ($rose(program_fault_code));
  C_HALT: cover property ($rose(halt_alarm_code) && $past(servo_on));
endmodule

bind psal_core psal_core_asserts chk_u (.ref_clk, .rst, .bus, .rdata,
  .emergency_halt_input, .halt_request_input, .other_alarm_input,
  .fault_clear_input, .chan, .servo_on, .dyn_brake, .halt_alarm_code,
  .program_fault_code, .in_operation, .run_start);
`default_nettype wire

// [verif/psal_host_model.sv]
// Host controller model that drives the discrete inputs of the block.
`default_nettype none
module psal_host_model
  import psal_pkg::*;
#(
  parameter int SEL_HOLD_CYC = 20000 // 1 ms settling at 20 MHz.
)
(
  input  wire logic          ref_clk,                // Clock.
  output var  logic          emergency_halt_input,   // Halt contact.
  output var  logic          input_port_five,        // Start contact.
  output var  logic [7:0]    program_channel_select, // Channel number.
  output var  psal_chan_type chan,                   // Channel info.
  output var  logic          fault_clear_input,      // Fault clear.
  output var  logic          halt_request_input,     // Stop request.
  output var  logic          other_alarm_input,      // Inhibiting alarm.
  output var  logic          exec_done               // Program done.
);
  // Contacts start open, as if nothing were wired yet.
  initial begin
    {emergency_halt_input, halt_request_input, other_alarm_input} = 3'h0;
    {fault_clear_input, exec_done, input_port_five} = 3'h0;
    program_channel_select = 8'h00;
    chan = '0;
  end

  // Levels in order: halt pin, stop, alarm, clear, done.
  task automatic set_lines(input logic [4:0] v);
    @(posedge ref_clk);
    {emergency_halt_input, halt_request_input, other_alarm_input,
     fault_clear_input, exec_done} <= v;
  endtask

  task automatic set_chan(input psal_chan_type c);
    @(posedge ref_clk);
    chan <= c;
  endtask

  // The channel must settle long before any start edge.
  task automatic select(input logic [7:0] ch);
    @(posedge ref_clk);
    program_channel_select <= ch;
    repeat (SEL_HOLD_CYC) @(posedge ref_clk);
  endtask

  task automatic press(input int n);
    @(posedge ref_clk);
    input_port_five <= 1'b1;
    repeat (n) @(posedge ref_clk);
    input_port_five <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/psal_core_tb_top.sv]
// Self-checking bench for the program start alarm logic.
`default_nettype none
module psal_core_tb_top
  import psal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          ref_clk, rst, irq, servo_on, dyn_brake, in_operation, ce;
  logic          emergency_halt_input, input_port_five, run_start;
  logic          fault_clear_input, halt_request_input, other_alarm_input;
  logic          exec_done, halt_alarm_code, program_fault_code;
  logic [1:0]    fault_subcode;
  logic [7:0]    program_channel_select, run_channel;
  logic [31:0]   rdata;
  psal_bus_type  bus;
  psal_chan_type chan;
  int            errors, checks;

  psal_host_model host_u (.ref_clk, .emergency_halt_input, .input_port_five,
    .program_channel_select, .chan, .fault_clear_input, .halt_request_input,
    .other_alarm_input, .exec_done);
  psal_core dut_u (.ref_clk, .rst, .ce, .bus, .rdata, .irq,
    .emergency_halt_input, .input_port_five, .program_channel_select, .chan,
    .fault_clear_input, .halt_request_input, .other_alarm_input, .exec_done,
    .servo_on, .dyn_brake, .halt_alarm_code, .program_fault_code,
    .fault_subcode, .in_operation, .run_start, .run_channel);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  always #25 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  // Read data is looked at in the one cycle that carries it.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1;
    check("rdata", rdata, e);
  endtask

  // One start edge, then a bounded wait for the verdict.
  task automatic attempt(input psal_chan_type c, input logic ok,
                         input logic [1:0] code, input logic busy);
    host_u.set_chan(c);
    host_u.press(1);
    for (int i = 0; i < 20 && !run_start && !program_fault_code; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check("run_start", run_start, ok);
    check("fault", program_fault_code, !ok);
    check("in_operation", in_operation, ok | busy);
    if (!ok) check("subcode", fault_subcode, code);
    wr(REG_CTRL, 32'h7);
    check("fault_cleared", program_fault_code, 1'b0);
  endtask

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  psal_chan_type tc[4] = '{'{1'b0, 1'b0, 1'b0, 8'h00}, '{1'b1, 1'b0, 1'b1,
    8'h00}, '{1'b1, 1'b1, 1'b0, 8'h05}, '{1'b1, 1'b0, 1'b0, 8'h00}};
  logic [1:0]    tcode[4] = '{2'h1, 2'h2, 2'h2, 2'h3};

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    bus = '0;
    errors = 0;
    checks = 0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check("halt_open", halt_alarm_code, 1'b1);
    check("brake", {servo_on, dyn_brake}, 2'b01);
    host_u.press(4);
    repeat (300) @(posedge ref_clk);
    check("chatter", program_fault_code, 1'b0);
    rdchk(REG_CTRL, 32'h0000_0a01);
    wr(REG_CTRL, 32'h0000_0002);
    check("halt_no", {halt_alarm_code, servo_on}, 2'b01);
    host_u.set_lines(5'b10000);
    wr(REG_SCALE, 32'h4);
    check("halt_on", {halt_alarm_code, servo_on, dyn_brake}, 3'b101);
    wr(REG_CTRL, 32'h0000_0003);
    check("halt_off", {halt_alarm_code, servo_on}, 2'b01);
    wr(REG_MASK, 32'h7);
    check("irq", irq, 1'b1);
    rdchk(REG_STATUS, 32'h1);
    check("irq_cleared", irq, 1'b0);
    host_u.select(8'h05);
    attempt('{1'b1, 1'b1, 1'b0, 8'h04}, 1'b1, 2'h0, 1'b0);
    check("run_channel", run_channel, 8'h05);
    rdchk(REG_STATUS, 32'h4);
    attempt('{1'b1, 1'b1, 1'b0, 8'h04}, 1'b0, 2'h0, 1'b1);
    host_u.set_lines(5'b10001);
    host_u.set_lines(5'b10000);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) host_u.set_lines(5'b11000);
      attempt(tc[i], 1'b0, tcode[i], 1'b0);
    end
    host_u.set_lines(5'b10100);
    host_u.set_lines(5'b10110);
    attempt(tc[3], 1'b0, 2'h3, 1'b0);
    host_u.set_lines(5'b10010);
    repeat (4) @(posedge ref_clk);
    host_u.set_lines(5'b10000);
    #1;
    check("clear_input", program_fault_code, 1'b0);
    wr(REG_CTRL, 32'h0000_0001);
    attempt('{1'b1, 1'b1, 1'b0, 8'h00}, 1'b0, 2'h2, 1'b0);
    rdchk(REG_HIST, 32'h6);
    wr(REG_CTRL, 32'h0001_0003);
    rdchk(REG_HIST, 32'h7);
    rdchk(8'h20, 32'h0);
    attempt('{1'b1, 1'b0, 1'b0, 8'h00}, 1'b1, 2'h0, 1'b0);
    host_u.set_lines(5'b00000);
    repeat (3) @(posedge ref_clk);
    #1;
    check("halt_run", {halt_alarm_code, in_operation, dyn_brake}, 3'b101);
    host_u.set_lines(5'b10000);
    repeat (3) @(posedge ref_clk);
    #1;
    check("halt_gone", halt_alarm_code, 1'b0);
    // A halt pulse that comes and goes while frozen must leave no trace.
    @(posedge ref_clk);
    ce <= 1'b0;
    host_u.set_lines(5'b00000);
    repeat (3) @(posedge ref_clk);
    host_u.set_lines(5'b10000);
    @(posedge ref_clk);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("freeze", halt_alarm_code, 1'b0);
    final_report();
  end

  // One settling wait of 1 ms dominates the run.
  initial begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
